// ---- l3eq_consts.svh ----
// Purpose: offsets, field positions, masks and reset values of the lane 3 register pair
// Assumes: included by its bare name wherever the constants are needed
// Notes: definitions only
`ifndef L3EQ_CONSTS_SVH
`define L3EQ_CONSTS_SVH

// ============================================================
// register offsets
`define L3EQ_CTRL_ADDR 8'h0B
`define L3EQ_ENBL_ADDR 8'h0C

// ============================================================
// reset values and write masks
`define L3EQ_CTRL_RESET 8'h00
`define L3EQ_ENBL_RESET 8'h00
`define L3EQ_CTRL_WMASK 8'hFF
`define L3EQ_ENBL_WMASK 8'h07
`define L3EQ_UNMAPPED_DATA 8'h00

// ============================================================
// control register field positions
`define L3EQ_SPARE_BIT 7
`define L3EQ_EQ_LEVEL_HI 6
`define L3EQ_EQ_LEVEL_LO 4
`define L3EQ_DC_BOOST_BIT 3
`define L3EQ_EQ_DC_LEVEL_BIT 2
`define L3EQ_GAIN_HI 1
`define L3EQ_GAIN_LO 0

// ============================================================
// enable register field positions
`define L3EQ_PEAK_BIT 2
`define L3EQ_EQ_OFF_BIT 1
`define L3EQ_DRV_OFF_BIT 0
`define L3EQ_ENBL_RO_HI 7
`define L3EQ_ENBL_RO_LO 3

`endif

// ---- l3eq_pkg.sv ----
// Purpose: types shared by the lane 3 register modules
// Assumes: field layout matches the constants header
// Notes: packed structs overlay the stored bytes bit for bit
package l3eq_pkg;

	// ============================================================
	// control register layout
	typedef struct packed {
		logic spare_bit;
		logic [2:0] eq_level_code;
		logic output_dc_boost;
		logic equalizer_dc_level;
		logic [1:0] input_gain_code;
	} l3eq_ctrl_t;

	// ============================================================
	// enable register layout
	typedef struct packed {
		logic [4:0] zero_bits;
		logic output_ac_peaking;
		logic equalizer_stage_off;
		logic output_stage_off;
	} l3eq_enbl_t;

endpackage : l3eq_pkg

// ---- l3eq_reg_if.sv ----
// Purpose: write strobes and stored values between bus decode and storage
// Assumes: single clock domain
// Notes: store modport owns the stored bytes
`timescale 1ns/1ps
`default_nettype none

interface l3eq_reg_if;
	logic wr_ctrl;
	logic wr_enbl;
	logic [7:0] wdata;
	l3eq_pkg::l3eq_ctrl_t ctrl;
	l3eq_pkg::l3eq_enbl_t enbl;

	modport store (input wr_ctrl, input wr_enbl, input wdata, output ctrl, output enbl);
	modport user (output wr_ctrl, output wr_enbl, output wdata, input ctrl, input enbl);
endinterface : l3eq_reg_if

`default_nettype wire

// ---- l3eq_store.sv ----
// Purpose: storage of the lane 3 control and enable bytes
// Assumes: write strobes are one-cycle pulses on core_clk
// Notes: read-only enable bits are masked off on write
`timescale 1ns/1ps
`default_nettype none
`include "l3eq_consts.svh"

module l3eq_store (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// register traffic
	l3eq_reg_if.store regs
);

	// ============================================================
	// control byte, every bit writable
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			regs.ctrl <= `L3EQ_CTRL_RESET;
		end else if (regs.wr_ctrl) begin
			regs.ctrl <= regs.wdata & `L3EQ_CTRL_WMASK;
		end
	end

	// ============================================================
	// enable byte, upper bits held at zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			regs.enbl <= `L3EQ_ENBL_RESET;
		end else if (regs.wr_enbl) begin
			regs.enbl <= regs.wdata & `L3EQ_ENBL_WMASK;
		end
	end

endmodule : l3eq_store

`default_nettype wire

// ---- l3eq_regs.sv ----
// Purpose: lane 3 equalizer configuration registers behind the serial register port
// Assumes: the serial front end presents one-cycle read and write strobes on core_clk
// Notes: read data appear one cycle after the read strobe; field outputs lag storage by one cycle
`timescale 1ns/1ps
`default_nettype none
`include "l3eq_consts.svh"

// Functional notes
// - A 3-bit equalization level sits in control bits 6..4, 000 weakest and 111 strongest.
// - Control bit 3 selects output DC boost, 0 for 0 dB and 1 for 6 dB.
// - Control bit 2 selects the equalizer DC level, 0 for -6 dB and 1 for 0 dB.
// - Control bits 1..0 stand in for the input gain strap: 00 low, 01 middle, 11 high.
// - Enable bit 2 turns on 6 dB output AC peaking when set.
// - Enable bit 1 set disables the equalizer stage, clear keeps it on.
// - Enable bit 0 set disables the output driver stage, clear keeps it on.
// - Both registers reset to zero, enable bits 7..3 read zero, control bit 7 is a spare store.
module l3eq_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// register port from the serial front end
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	// lane 3 analog controls
	output logic [2:0] eq_level_code,
	output logic output_dc_boost,
	output logic equalizer_dc_level,
	output logic [1:0] input_gain_code,
	output logic output_ac_peaking,
	output logic equalizer_stage_off,
	output logic output_stage_off
);

	// ============================================================
	// address decode and storage
	l3eq_reg_if regs ();

	logic hit_ctrl;
	logic hit_enbl;
	logic [7:0] rdata_next;

	assign hit_ctrl = (reg_addr == `L3EQ_CTRL_ADDR);
	assign hit_enbl = (reg_addr == `L3EQ_ENBL_ADDR);
	assign regs.wr_ctrl = reg_wr_en && hit_ctrl;
	assign regs.wr_enbl = reg_wr_en && hit_enbl;
	assign regs.wdata = reg_wdata;

	l3eq_store u_store (
		.core_clk(core_clk),
		.nrst(nrst),
		.regs(regs)
	);

	// ============================================================
	// readback mux, unmapped reads zero
	always_comb begin
		rdata_next = `L3EQ_UNMAPPED_DATA;
		if (hit_ctrl) begin
			rdata_next = regs.ctrl;
		end else if (hit_enbl) begin
			rdata_next = regs.enbl;
		end
	end

	// read data register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= rdata_next;
			end
		end
	end

	// ============================================================
	// control field outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			eq_level_code <= 3'h0;
			output_dc_boost <= 1'b0;
			equalizer_dc_level <= 1'b0;
			input_gain_code <= 2'h0;
		end else begin
			eq_level_code <= regs.ctrl.eq_level_code;
			output_dc_boost <= regs.ctrl.output_dc_boost;
			equalizer_dc_level <= regs.ctrl.equalizer_dc_level;
			input_gain_code <= regs.ctrl.input_gain_code;
		end
	end

	// enable field outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			output_ac_peaking <= 1'b0;
			equalizer_stage_off <= 1'b0;
			output_stage_off <= 1'b0;
		end else begin
			output_ac_peaking <= regs.enbl.output_ac_peaking;
			equalizer_stage_off <= regs.enbl.equalizer_stage_off;
			output_stage_off <= regs.enbl.output_stage_off;
		end
	end

	// ============================================================
	// checks on the stored fields and their outputs
	a_eq_level_follow: assert property (@(posedge core_clk) disable iff (!nrst)
		regs.wr_ctrl |-> ##2 (eq_level_code == $past(reg_wdata[6:4], 2)))
		else $error("equalization level did not follow control write");

	a_dc_boost_follow: assert property (@(posedge core_clk) disable iff (!nrst)
		regs.wr_ctrl ##1 !regs.wr_ctrl |-> ##1 (output_dc_boost == $past(reg_wdata[3], 2)))
		else $error("dc boost did not follow control write");

	a_dc_level_follow: assert property (@(posedge core_clk) disable iff (!nrst)
		(regs.wr_ctrl && reg_wdata[2]) |-> ##2 equalizer_dc_level)
		else $error("equalizer dc level not set by control write");

	a_gain_code_follow: assert property (@(posedge core_clk) disable iff (!nrst)
		regs.wr_ctrl |-> ##2 (input_gain_code == $past(reg_wdata[1:0], 2)))
		else $error("gain code did not follow control write");

	a_peaking_follow: assert property (@(posedge core_clk) disable iff (!nrst)
		(regs.wr_enbl && !reg_wdata[2]) |-> ##2 !output_ac_peaking)
		else $error("ac peaking not cleared by enable write");

	a_eq_off_follow: assert property (@(posedge core_clk) disable iff (!nrst)
		regs.wr_enbl |-> ##2 (equalizer_stage_off == $past(reg_wdata[1], 2)))
		else $error("equalizer stage off did not follow enable write");

	a_drv_off_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		(!regs.wr_enbl [*3]) |-> $stable(output_stage_off))
		else $error("driver stage off changed without a write");

	a_enbl_upper_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd_en && hit_enbl) |=> (reg_rd_valid && reg_rdata[7:3] == 5'h00))
		else $error("enable register upper bits read nonzero");

	a_ctrl_readback: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_wr_en && hit_ctrl) ##1 (reg_rd_en && hit_ctrl && !reg_wr_en)
		|=> (reg_rdata == $past(reg_wdata, 2)))
		else $error("control readback differs from written byte");

	// ============================================================
	// complementary field checks and read port behaviour
	// dc level clears
	a_dc_level_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		(regs.wr_ctrl && !reg_wdata[2]) |-> ##2 !equalizer_dc_level)
		else $error("equalizer dc level not cleared by control write");

	a_peaking_set: assert property (@(posedge core_clk) disable iff (!nrst)
		(regs.wr_enbl && reg_wdata[2]) |-> ##2 output_ac_peaking)
		else $error("ac peaking not set by enable write");

	a_drv_off_follow: assert property (@(posedge core_clk) disable iff (!nrst)
		regs.wr_enbl |-> ##2 (output_stage_off == $past(reg_wdata[0], 2)))
		else $error("driver stage off did not follow enable write");

	a_spare_bit_store: assert property (@(posedge core_clk) disable iff (!nrst)
		regs.wr_ctrl |=> (regs.ctrl.spare_bit == $past(reg_wdata[7])))
		else $error("control spare bit not stored");

	a_enbl_zero_store: assert property (@(posedge core_clk) disable iff (!nrst)
		(regs.enbl.zero_bits == 5'h00))
		else $error("enable register upper bits stored nonzero");

	a_ctrl_gap_readback: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_wr_en && hit_ctrl) ##1 !reg_wr_en ##1 (reg_rd_en && hit_ctrl && !reg_wr_en)
		|=> (reg_rdata == $past(reg_wdata, 3)))
		else $error("control readback after gap differs from written byte");

	a_enbl_gap_readback: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_wr_en && hit_enbl) ##1 !reg_wr_en ##1 (reg_rd_en && hit_enbl && !reg_wr_en)
		|=> (reg_rdata == {5'h00, $past(reg_wdata[2:0], 3)}))
		else $error("enable readback differs from written bits");

	a_rd_valid_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_rd_en |=> reg_rd_valid)
		else $error("read valid missing after read strobe");

	a_rd_valid_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		!reg_rd_en |=> !reg_rd_valid)
		else $error("read valid high without read strobe");

	a_rdata_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data changed without read strobe");

	a_unmapped_rd_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd_en && !hit_ctrl && !hit_enbl) |=> (reg_rdata == `L3EQ_UNMAPPED_DATA))
		else $error("unmapped read returned nonzero data");

	a_unmapped_wr_keep: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_wr_en && !hit_ctrl && !hit_enbl) |=> ($stable(regs.ctrl) && $stable(regs.enbl)))
		else $error("unmapped write changed a stored byte");

endmodule : l3eq_regs

`default_nettype wire

// ---- l3eq_host_model.sv ----
// Purpose: serial host stand-in driving the lane 3 register port
// Assumes: one-cycle strobes, read answer one cycle later
// Notes: released write data is inverted so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
`include "l3eq_consts.svh"

module l3eq_host_model (
	// clock
	input wire logic core_clk,
	// register port
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic [7:0] reg_wdata,
	output logic reg_rd_en,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid
);
	// ============================================================
	// idle levels
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
		reg_rd_en = 1'b0;
	end

	// one byte write, strobe held for one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(posedge core_clk);
		#1 reg_wr_en = 1'b0;
		reg_wdata = ~d;
	endtask : wr

	// one byte read, answer taken the cycle after
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_rd_en = 1'b1;
		@(posedge core_clk);
		#1 reg_rd_en = 1'b0;
		d = reg_rdata;
		v = reg_rd_valid;
	endtask : rd

	// write then read on the very next cycle, no gap between strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] dw, output logic [7:0] d,
		output logic v);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_wdata = dw;
		reg_wr_en = 1'b1;
		@(posedge core_clk);
		#1 reg_wr_en = 1'b0;
		reg_wdata = ~dw;
		reg_rd_en = 1'b1;
		@(posedge core_clk);
		#1 reg_rd_en = 1'b0;
		d = reg_rdata;
		v = reg_rd_valid;
	endtask : wr_rd

	task automatic set_unity();
		wr(`L3EQ_CTRL_ADDR, 8'h04);
	endtask : set_unity
endmodule : l3eq_host_model

`default_nettype wire

// ---- lane3_equalizer_config_regs_tb.sv ----
// Purpose: self-checking bench for the lane 3 register pair
// Assumes: host model issues all register traffic
// Notes: field outputs checked one cycle after each write lands
`timescale 1ns/1ps
`default_nettype none
`include "l3eq_consts.svh"

module lane3_equalizer_config_regs_tb;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv, d, ctl_f, enb_f;
	logic reg_wr_en, reg_rd_en, reg_rd_valid, vv;
	logic [2:0] eq_level_code;
	logic [1:0] input_gain_code;
	logic output_dc_boost, equalizer_dc_level;
	logic output_ac_peaking, equalizer_stage_off, output_stage_off;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;

	// ============================================================
	// clock, harness
	always #2.5 core_clk = ~core_clk;
	assign ctl_f = {1'b0, eq_level_code, output_dc_boost, equalizer_dc_level, input_gain_code};
	assign enb_f = {5'h00, output_ac_peaking, equalizer_stage_off, output_stage_off};

	l3eq_regs uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .eq_level_code(eq_level_code),
		.output_dc_boost(output_dc_boost), .equalizer_dc_level(equalizer_dc_level),
		.input_gain_code(input_gain_code), .output_ac_peaking(output_ac_peaking),
		.equalizer_stage_off(equalizer_stage_off), .output_stage_off(output_stage_off));
	l3eq_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid));

	// ============================================================
	// compare and close helpers
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rdv, vv);
		chk("rd_valid", 8'h01, {7'h00, vv});
		chk("rdata", e, rdv);
	endtask : rchk

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ============================================================
	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		#1 nrst = 1'b1;
		chk("ctl_fields", 8'h00, ctl_f);
		chk("enb_fields", 8'h00, enb_f);
		rchk(`L3EQ_CTRL_ADDR, 8'h00);
		rchk(`L3EQ_ENBL_ADDR, 8'h00);
		// every level, gain code, and enable combination
		for (int i = 0; i < 8; i++) begin
			d = {i[0], i[2:0], i[1], i[2], i[1:0]};
			host.wr(`L3EQ_CTRL_ADDR, d);
			@(posedge core_clk);
			#1 chk("ctl_fields", {1'b0, d[6:0]}, ctl_f);
			rchk(`L3EQ_CTRL_ADDR, d);
			host.wr(`L3EQ_ENBL_ADDR, 8'hF8 | 8'(i));
			@(posedge core_clk);
			#1 chk("enb_fields", {5'h00, 3'(i)}, enb_f);
			rchk(`L3EQ_ENBL_ADDR, {5'h00, 3'(i)});
		end
		// unmapped place leaves both bytes alone
		host.wr(8'h0D, 8'h00);
		rchk(8'h0D, 8'h00);
		rchk(`L3EQ_CTRL_ADDR, 8'hFF);
		rchk(`L3EQ_ENBL_ADDR, 8'h07);
		// back to back write and read of the control byte
		host.wr_rd(`L3EQ_CTRL_ADDR, 8'h5A, rdv, vv);
		chk("b2b_rd_valid", 8'h01, {7'h00, vv});
		chk("b2b_rdata", 8'h5A, rdv);
		host.set_unity();
		@(posedge core_clk);
		#1 chk("dc_level", 8'h01, {7'h00, equalizer_dc_level});
		// asynchronous reset in mid-run
		@(posedge core_clk);
		#1 nrst = 1'b0;
		#1 chk("ctl_fields", 8'h00, ctl_f);
		chk("enb_fields", 8'h00, enb_f);
		repeat (2) @(posedge core_clk);
		#1 nrst = 1'b1;
		rchk(`L3EQ_ENBL_ADDR, 8'h00);
		rchk(`L3EQ_CTRL_ADDR, 8'h00);
		report_and_stop();
	end
endmodule : lane3_equalizer_config_regs_tb

`default_nettype wire
